// File: rtl/labc_block.sv
// one logic_array_block: ten logic_elements, cascade chain, block control, local areas
// assumes neighbours and row routing are wired by the enclosing fabric
//
// How it works
// - a block holds ten logic elements, chains, block control and local areas
// - each element has a sixteen-entry lookup table over four inputs
// - each element has a flip-flop, local and routing outputs; all but the first have a chain stage
// - four global lines drive flip-flop controls; element one may drive them
// - chain combines table output with previous stage by AND or De Morgan OR
// - every chained element adds four more inputs to the function
// - last element of an OR chain cannot register; AND chain may
// - first element never joins a chain; it may make block controls
// - chains longer than nine stages continue through the chain output port
// - chain links skip one block, even to even and odd to odd
// - a chain never crosses the row centre; it stops and restarts there
// - elements one to five drive right, six to ten drive left
// - inputs a and c come from left area, b and d from right area
// - local areas join elements in this block, neighbours and I/O pins
// - row lines enter the areas; routing outputs feed the row
// - first and last column blocks drive both sides with every element
// - each element input selects any signal of its one local area, left for a and c, right for b and d
// - column lines reach the block only through row lines
`timescale 1ns/1ns
module labc_block
    import labc_pkg::*;
#(
    parameter int P_BLK_IDX = 0,
    parameter int P_ROW_LEN = LABC_ROW_LEN,
    parameter int P_ROW_W = LABC_ROW_W
) (
    // clock, reset, enable
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // static configuration
    input wire logic i_cfg_we,
    input wire labc_elem_cfg_s [LABC_N_ELEM-1:0] i_cfg_elem,
    input wire labc_blk_cfg_s i_cfg_blk,
    // global control lines
    input wire logic [LABC_N_GLB-1:0] i_glb,
    // local areas from neighbours and row lines
    input wire logic [LABC_N_ELEM-1:0] i_loc_l,
    input wire logic [LABC_N_ELEM-1:0] i_loc_r,
    input wire logic [P_ROW_W-1:0] i_row,
    // cascade from two blocks back
    input wire logic i_casc_in,
    // element outputs
    output logic [LABC_N_ELEM-1:0] o_route,
    output logic [LABC_N_ELEM-1:0] o_loc_r,
    output logic [LABC_N_ELEM-1:0] o_loc_l,
    // cascade to two blocks on
    output logic o_casc_out,
    // drive onto global lines
    output logic [LABC_N_GLB-1:0] o_glb_drv
);

    localparam int AW = P_ROW_W + 2 * LABC_N_ELEM;
    localparam int LAST = LABC_N_ELEM - 1;
    localparam int CTR = P_ROW_LEN / 2;
    localparam bit EDGE = (P_BLK_IDX == 0) || (P_BLK_IDX == P_ROW_LEN - 1);
    localparam bit STOP = ((P_BLK_IDX < CTR) && (P_BLK_IDX + LABC_SKIP >= CTR))
        || (P_BLK_IDX + LABC_SKIP >= P_ROW_LEN);
    localparam bit START = (P_BLK_IDX >= CTR) && (P_BLK_IDX < CTR + LABC_SKIP);

    // static configuration store
    labc_elem_cfg_s [LABC_N_ELEM-1:0] cfg_elem_q;
    labc_blk_cfg_s cfg_blk_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_elem_q <= {LABC_N_ELEM{LABC_ELEM_CFG_RST}};
            cfg_blk_q <= LABC_BLK_CFG_RST;
        end else if (i_ce && i_cfg_we) begin
            cfg_elem_q <= i_cfg_elem;
            cfg_blk_q <= i_cfg_blk;
        end
    end

    // local interconnect areas
    wire [AW-1:0] area_l;
    wire [AW-1:0] area_r;
    assign area_l = {o_route, i_loc_l, i_row};
    assign area_r = {o_route, i_loc_r, i_row};

    function automatic logic pick(input logic [AW-1:0] area,
                                  input logic [LABC_SEL_W-1:0] sel);
        logic v;
        v = 1'b0;
        if (int'(sel) < AW) begin
            v = area[sel];
        end
        return v;
    endfunction

    // block control
    wire is_or;
    wire neutral;
    wire casc_in_eff;
    wire clk_en;
    wire clr;
    wire pre;
    assign is_or = (cfg_blk_q.casc_mode == LABC_CASC_OR);
    assign neutral = ~is_or;
    assign casc_in_eff = START ? neutral : i_casc_in;

    wire [LABC_N_ELEM-1:0] lut_o;
    wire [LABC_N_ELEM-1:0] chain;
    wire [LABC_N_ELEM-1:0] casc_on;
    wire [LABC_N_ELEM-1:0] casc_end;
    wire [LABC_N_ELEM-1:0] use_eff;
    wire [LABC_N_ELEM-1:0] elem_out;
    logic [LABC_N_ELEM-1:0] ff_q;

    assign clk_en = (cfg_blk_q.ce_src < LABC_CE_FROM_ELEM) ?
        i_glb[cfg_blk_q.ce_src[LABC_GSEL_W-1:0]] :
        ((cfg_blk_q.ce_src == LABC_CE_FROM_ELEM) ? chain[LABC_CTL_ELEM] : 1'b1);
    assign clr = cfg_blk_q.clr_en & i_glb[cfg_blk_q.clr_sel];
    assign pre = cfg_blk_q.pre_en & i_glb[cfg_blk_q.pre_sel];

    // logic elements
    for (genvar g = 0; g < LABC_N_ELEM; g++) begin : g_elem
        wire in_a;
        wire in_b;
        wire in_c;
        wire in_d;
        wire prev;
        wire and_v;
        wire or_v;

        assign in_a = pick(area_l, cfg_elem_q[g].sel_a);
        assign in_c = pick(area_l, cfg_elem_q[g].sel_c);
        assign in_b = pick(area_r, cfg_elem_q[g].sel_b);
        assign in_d = pick(area_r, cfg_elem_q[g].sel_d);
        assign lut_o[g] = cfg_elem_q[g].lut[{in_d, in_c, in_b, in_a}];

        if (g == LABC_CTL_ELEM) begin : g_ctl
            assign casc_on[g] = 1'b0;
            assign prev = neutral;
        end else if (g == LABC_CASC_FIRST) begin : g_head
            assign casc_on[g] = cfg_elem_q[g].casc_en;
            assign prev = casc_in_eff;
        end else begin : g_mid
            assign casc_on[g] = cfg_elem_q[g].casc_en;
            assign prev = chain[g-1];
        end

        assign and_v = lut_o[g] & prev;
        assign or_v = ~(~lut_o[g] & ~prev);
        assign chain[g] = casc_on[g] ? (is_or ? or_v : and_v) : lut_o[g];

        if (g == LAST) begin : g_tail
            assign casc_end[g] = casc_on[g];
        end else begin : g_body
            assign casc_end[g] = casc_on[g] & ~cfg_elem_q[g+1].casc_en;
        end

        assign use_eff[g] = cfg_elem_q[g].use_reg & ~(casc_end[g] & is_or);

        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                ff_q[g] <= 1'b0;
            end else if (i_ce) begin
                if (clr) begin
                    ff_q[g] <= 1'b0;
                end else if (pre) begin
                    ff_q[g] <= 1'b1;
                end else if (clk_en) begin
                    ff_q[g] <= chain[g];
                end
            end
        end

        assign elem_out[g] = use_eff[g] ? ff_q[g] : chain[g];

        a_or_end_comb: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
            (casc_end[g] && is_or) |-> (elem_out[g] == chain[g]))
            else $error("or chain end used its register");
    end

    // output drivers
    wire [LABC_N_ELEM-1:0] loc_r_d;
    wire [LABC_N_ELEM-1:0] loc_l_d;
    wire casc_out_d;
    wire [LABC_N_GLB-1:0] glb_d;
    assign loc_r_d = EDGE ? elem_out :
        {{LABC_HALF{1'b0}}, elem_out[LABC_HALF-1:0]};
    assign loc_l_d = EDGE ? elem_out :
        {elem_out[LAST:LABC_HALF], {LABC_HALF{1'b0}}};
    assign casc_out_d = STOP ? neutral : chain[LAST];
    assign glb_d = cfg_blk_q.glb_drv_en & {LABC_N_GLB{elem_out[LABC_CTL_ELEM]}};

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_route <= '0;
            o_loc_r <= '0;
            o_loc_l <= '0;
            o_casc_out <= 1'b0;
            o_glb_drv <= '0;
        end else if (i_ce) begin
            o_route <= elem_out;
            o_loc_r <= loc_r_d;
            o_loc_l <= loc_l_d;
            o_casc_out <= casc_out_d;
            o_glb_drv <= glb_d;
        end
    end

    // checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_cfg_write;
        i_ce && i_cfg_we;
    endsequence

    sequence s_clear_hit;
        i_ce && clr;
    endsequence

    property p_cfg_taken;
        s_cfg_write |=> (cfg_elem_q == $past(i_cfg_elem)) && (cfg_blk_q == $past(i_cfg_blk));
    endproperty

    property p_clear_all;
        s_clear_hit |=> (ff_q == '0);
    endproperty

    a_cfg_taken_now: assert property (p_cfg_taken)
        else $error("configuration not loaded");

    a_cfg_held_static: assert property (!(i_ce && i_cfg_we) |=> $stable(cfg_elem_q))
        else $error("configuration changed without load");

    a_clear_wins_all: assert property (p_clear_all)
        else $error("global clear did not clear flip-flops");

    a_preset_sets_all: assert property ((i_ce && !clr && pre) |=> (ff_q == '1))
        else $error("global preset did not set flip-flops");

    a_hold_no_enable: assert property ((i_ce && !clr && !pre && !clk_en) |=> $stable(ff_q))
        else $error("flip-flops moved without enable");

    a_route_follows: assert property (i_ce |=> (o_route == $past(elem_out)))
        else $error("routing output does not follow element");

    a_right_drivers: assert property (i_ce |=>
        (o_loc_r[LABC_HALF-1:0] == $past(elem_out[LABC_HALF-1:0])))
        else $error("right local drivers wrong");

    a_left_drivers: assert property (i_ce |=>
        (o_loc_l[LAST:LABC_HALF] == $past(elem_out[LAST:LABC_HALF])))
        else $error("left local drivers wrong");

    a_inner_one_side: assert property (!EDGE |->
        (o_loc_r[LAST:LABC_HALF] == '0) && (o_loc_l[LABC_HALF-1:0] == '0))
        else $error("inner block drove both sides");

    a_first_not_chain: assert property (chain[LABC_CTL_ELEM] == lut_o[LABC_CTL_ELEM])
        else $error("first element joined a chain");

    a_centre_stops: assert property ((STOP && i_ce) |=> (o_casc_out == $past(neutral)))
        else $error("chain crossed the row centre");

    a_freeze_state: assert property (!i_ce |=> $stable(o_route) && $stable(o_casc_out))
        else $error("state moved with enable low");

endmodule

// File: rtl/labc_pkg.sv
// shared constants and carriers for the logic array block with cascade chain
// assumes one system clock; configuration is loaded before normal operation
package labc_pkg;

    // block shape
    localparam int LABC_N_ELEM = 10;
    localparam int LABC_HALF = 5;
    localparam int LABC_N_IN = 4;
    localparam int LABC_LUT_W = 16;
    localparam int LABC_N_GLB = 4;
    localparam int LABC_SEL_W = 6;
    localparam int LABC_GSEL_W = 2;
    localparam int LABC_CE_W = 3;
    localparam int LABC_CTL_ELEM = 0;
    localparam int LABC_CASC_FIRST = 1;

    // row defaults
    localparam int LABC_ROW_LEN = 22;
    localparam int LABC_ROW_W = 16;
    localparam int LABC_SKIP = 2;

    // control source codes for the flip-flop clock enable
    localparam logic [LABC_CE_W-1:0] LABC_CE_FROM_ELEM = 3'h4;

    // cascade combination
    typedef enum logic {
        LABC_CASC_AND,
        LABC_CASC_OR
    } labc_casc_e;

    // per logic_element configuration
    typedef struct packed {
        logic [LABC_LUT_W-1:0] lut;
        logic [LABC_SEL_W-1:0] sel_d;
        logic [LABC_SEL_W-1:0] sel_c;
        logic [LABC_SEL_W-1:0] sel_b;
        logic [LABC_SEL_W-1:0] sel_a;
        logic casc_en;
        logic use_reg;
    } labc_elem_cfg_s;

    // per logic_array_block control configuration
    typedef struct packed {
        labc_casc_e casc_mode;
        logic [LABC_CE_W-1:0] ce_src;
        logic clr_en;
        logic [LABC_GSEL_W-1:0] clr_sel;
        logic pre_en;
        logic [LABC_GSEL_W-1:0] pre_sel;
        logic [LABC_N_GLB-1:0] glb_drv_en;
    } labc_blk_cfg_s;

    localparam labc_elem_cfg_s LABC_ELEM_CFG_RST = '0;
    localparam labc_blk_cfg_s LABC_BLK_CFG_RST = '0;

endpackage

// File: testbench/labc_nbr_model.sv
// neighbour model: left and right blocks, row lines and cascade source
// assumes the bench calls drive() just after a falling clock edge
`timescale 1ns/1ns
module labc_nbr_model (
    // row lines and local areas
    output logic [15:0] o_row,
    output logic [9:0] o_loc_l,
    output logic [9:0] o_loc_r,
    // cascade from two blocks back
    output logic o_casc
);
    initial begin
        o_row = 16'h0000;
        o_loc_l = 10'h000;
        o_loc_r = 10'h000;
        o_casc = 1'h0;
    end

    // column traffic arrives only as row values
    task drive(input logic [15:0] row, input logic [9:0] l, r, input logic c);
        o_row = row;
        o_loc_l = l;
        o_loc_r = r;
        o_casc = c;
    endtask
endmodule

// File: testbench/test_logic_array_block_cascade.sv
// self-checking bench for one inner logic_array_block
// assumes the neighbour model stands on both sides and on the row lines
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_logic_array_block_cascade;
    import labc_pkg::*;
    logic i_clk_sys = 0, i_rst_n = 0, i_ce = 1, i_cfg_we = 0;
    labc_elem_cfg_s [LABC_N_ELEM-1:0] cfg_elem = '0;
    labc_blk_cfg_s cfg_blk = '0;
    logic [3:0] glb = 4'h0;
    logic [15:0] row;
    logic [9:0] loc_l, loc_r, route, lr, ll;
    logic casc_in, casc_out;
    logic [3:0] gdrv;
    int miscompares = 0, total_checks = 0;

    always #4 i_clk_sys = ~i_clk_sys;

    labc_nbr_model u_labc_nbr_model (.o_row(row), .o_loc_l(loc_l), .o_loc_r(loc_r),
        .o_casc(casc_in));
    labc_block #(.P_BLK_IDX(2), .P_ROW_LEN(22), .P_ROW_W(16)) u_labc_block (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_cfg_we(i_cfg_we),
        .i_cfg_elem(cfg_elem), .i_cfg_blk(cfg_blk), .i_glb(glb), .i_loc_l(loc_l),
        .i_loc_r(loc_r), .i_row(row), .i_casc_in(casc_in), .o_route(route),
        .o_loc_r(lr), .o_loc_l(ll), .o_casc_out(casc_out), .o_glb_drv(gdrv));

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    task automatic load();
        i_cfg_we = 1;
        cyc(1);
        i_cfg_we = 0;
        cyc(1);
    endtask

    function automatic labc_elem_cfg_s elem_cfg(input logic [15:0] lut,
                                                input logic [5:0] a, b, input logic ce, ur);
        elem_cfg = '0;
        elem_cfg.lut = lut;
        elem_cfg.sel_a = a;
        elem_cfg.sel_b = b;
        elem_cfg.casc_en = ce;
        elem_cfg.use_reg = ur;
    endfunction

    task automatic t_walk();
        cfg_elem[0] = elem_cfg(16'haaaa, 6'h00, 6'h00, 1'h0, 1'h0);
        cfg_blk.glb_drv_en = 4'hf;
        load();
        u_labc_nbr_model.drive(16'h0001, 10'h000, 10'h000, 1'h0);
        cyc(1);
        `CHK("route0", 1'h1, route[0])
        `CHK("loc_r0", 1'h1, lr[0])
        `CHK("loc_l0", 1'h0, ll[0])
        cyc(1);
        `CHK("glb_drv", 4'hf, gdrv)
        i_ce = 0;
        u_labc_nbr_model.drive(16'h0000, 10'h000, 10'h000, 1'h0);
        cyc(2);
        `CHK("route0_hold", 1'h1, route[0])
        i_ce = 1;
        cyc(1);
        `CHK("route0_low", 1'h0, route[0])
    endtask

    task automatic t_sides();
        cfg_elem[5] = elem_cfg(16'h6666, 6'h00, 6'h10, 1'h0, 1'h0);
        load();
        for (int i = 0; i < 4; i++) begin
            u_labc_nbr_model.drive({15'h0, i[0]}, {9'h0, ~i[1]}, {9'h0, i[1]}, 1'h0);
            cyc(1);
            `CHK("loc_l5", i[0] ^ i[1], ll[5])
            `CHK("loc_r5", 1'h0, lr[5])
        end
    endtask

    task automatic t_casc(input labc_casc_e m);
        cfg_elem = '0;
        cfg_elem[0] = elem_cfg(16'h0000, 6'h00, 6'h00, 1'h1, 1'h0);
        cfg_elem[1] = elem_cfg(16'haaaa, 6'h00, 6'h00, 1'h1, 1'h0);
        for (int k = 2; k < 10; k++) begin
            cfg_elem[k] = elem_cfg((m == LABC_CASC_AND) ? 16'hffff : 16'h0000,
                                   6'h0, 6'h0, 1'h1, 1'h0);
        end
        cfg_blk.casc_mode = m;
        load();
        for (int i = 0; i < 4; i++) begin
            u_labc_nbr_model.drive({15'h0, i[0]}, 10'h000, 10'h000, i[1]);
            cyc(1);
            `CHK("casc_out", (m == LABC_CASC_AND) ? (i[0] & i[1]) : (i[0] | i[1]), casc_out)
        end
    endtask

    task automatic t_flop();
        logic [3:0] g[4] = '{4'h0, 4'h0, 4'h4, 4'h6};
        logic r[4] = '{1'h1, 1'h0, 1'h0, 1'h1};
        logic e[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
        cfg_elem = '0;
        cfg_elem[0] = elem_cfg(16'haaaa, 6'h00, 6'h00, 1'h0, 1'h1);
        cfg_blk = '{LABC_CASC_AND, 3'h5, 1'h1, 2'h1, 1'h1, 2'h2, 4'h0};
        load();
        for (int i = 0; i < 4; i++) begin
            glb = g[i];
            u_labc_nbr_model.drive({15'h0, r[i]}, 10'h000, 10'h000, 1'h0);
            cyc(2);
            `CHK("flop0", e[i], route[0])
        end
        glb = 4'h0;
        u_labc_nbr_model.drive(16'h0000, 10'h000, 10'h000, 1'h0);
        cfg_blk.ce_src = LABC_CE_FROM_ELEM;
        load();
        u_labc_nbr_model.drive(16'h0001, 10'h000, 10'h000, 1'h0);
        cyc(2);
        `CHK("flop0_own_en", 1'h1, route[0])
        u_labc_nbr_model.drive(16'h0000, 10'h000, 10'h000, 1'h0);
        cyc(2);
        `CHK("flop0_own_hold", 1'h1, route[0])
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        test_done();
    end

    initial begin
        cyc(1);
        `CHK("route_rst", 10'h000, route)
        `CHK("casc_rst", 1'h0, casc_out)
        cyc(4);
        i_rst_n = 1;
        cyc(1);
        t_walk();
        t_sides();
        t_casc(LABC_CASC_AND);
        t_casc(LABC_CASC_OR);
        t_flop();
        test_done();
    end
endmodule
